//--- ldsv_pkg.sv
package ldsv_pkg;

    // synchronised comparator inputs, bit positions in the sync vector
    localparam int SYNC_W        = 9;
    localparam int SI_SUPPLY_OK  = 0;
    localparam int SI_VCC_RESET  = 1;
    localparam int SI_VALLEY_LOW = 2;
    localparam int SI_ZCD_SHORT  = 3;
    localparam int SI_BO_OFF     = 4;
    localparam int SI_BO_ON      = 5;
    localparam int SI_LOW_LINE   = 6;
    localparam int SI_HIGH_LINE  = 7;
    localparam int SI_OTA_SINK   = 8;

    // timing figures in their own units
    localparam int CLK_PERIOD_NS   = 10;
    localparam int TIMEOUT_NS      = 6500;
    localparam int DEAD_TIME_NS    = 40000;
    localparam int AUX_SHORT_MS    = 90;
    localparam int RESTART_S       = 4;
    localparam int DIM_RESET_S     = 3;
    localparam int LOW_LINE_MS     = 25;
    localparam int BO_BLANK_MS     = 25;
    localparam int CYC_PER_MS      = 1000000 / CLK_PERIOD_NS;
    localparam int CYC_PER_S       = 1000 * CYC_PER_MS;

    // derived cycle counts
    localparam logic [31:0] TIMEOUT_CYC   = 32'(TIMEOUT_NS / CLK_PERIOD_NS);
    localparam logic [11:0] DEAD_CYC      = 12'(DEAD_TIME_NS / CLK_PERIOD_NS);
    localparam logic [31:0] AUX_SHORT_CYC = 32'(AUX_SHORT_MS * CYC_PER_MS);
    localparam logic [31:0] RESTART_CYC   = 32'(RESTART_S * CYC_PER_S);
    localparam logic [31:0] DIM_RESET_CYC = 32'(DIM_RESET_S * CYC_PER_S);
    localparam logic [31:0] LOW_LINE_CYC  = 32'(LOW_LINE_MS * CYC_PER_MS);
    localparam logic [31:0] BO_BLANK_CYC  = 32'(BO_BLANK_MS * CYC_PER_MS);

    // dimming steps and their output current levels in percent
    localparam logic [1:0] DIM_FULL = 2'h0;
    localparam logic [1:0] DIM_70   = 2'h1;
    localparam logic [1:0] DIM_25   = 2'h2;
    localparam logic [1:0] DIM_5    = 2'h3;
    localparam logic [6:0] PCT_FULL = 7'h64;
    localparam logic [6:0] PCT_70   = 7'h46;
    localparam logic [6:0] PCT_25   = 7'h19;
    localparam logic [6:0] PCT_5    = 7'h05;

    // valley selection, low line / high line
    localparam logic [3:0] VAL_LL_FULL = 4'h1;
    localparam logic [3:0] VAL_HL_FULL = 4'h2;
    localparam logic [3:0] VAL_LL_70   = 4'h2;
    localparam logic [3:0] VAL_HL_70   = 4'h3;
    localparam logic [3:0] VAL_LL_LOW  = 4'h5;
    localparam logic [3:0] VAL_HL_LOW  = 4'h6;
    localparam logic [3:0] VAL_MAX     = 4'h9;

    typedef enum logic [1:0] {
        ST_OFF,
        ST_RUN,
        ST_WAIT,
        ST_LATCHED
    } ldsv_state_type;

endpackage

//--- ldsv_hold_timer.sv
`timescale 1ns/1ps
// counts while run is high, restarts when it drops
module ldsv_hold_timer #(
    parameter logic [31:0] LIMIT = 32'h0000_0010,
    parameter bit          WRAP  = 1'b0
) (
    // clock and reset
    input  wire logic sys_clk,
    input  wire logic rst_n,
    // condition and result
    input  wire logic run,
    output logic      expired
);

    typedef struct packed {
        logic [31:0] count;
        logic        expired;
    } ldsv_timer_type;

    ldsv_timer_type t_reg;
    ldsv_timer_type t_next;

    always_comb begin
        t_next = t_reg;
        if (!run) begin
            t_next.count   = 32'h0;
            t_next.expired = 1'b0;
        end else if (t_reg.count == LIMIT - 32'h1) begin
            // wrap mode gives a pulse every period, else a held level
            t_next.expired = 1'b1;
            t_next.count   = WRAP ? 32'h0 : t_reg.count;
        end else begin
            t_next.count   = t_reg.count + 32'h1;
            t_next.expired = WRAP ? 1'b0 : t_reg.expired;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            t_reg <= '0;
        end else begin
            t_reg <= t_next;
        end
    end

    assign expired = t_reg.expired;

endmodule

//--- ldsv_ctrl.sv
`timescale 1ns/1ps
// What this block does
// - compensation node grounded while off until first start, and after supply reset or short fault
// - 80 uA boost until amplifier sinks
// - maximum reference until valley sense exceeds 1 V
// - short timer and maximum reference survive supply cycles
// - retry at turn-on, keep compensation level
// - brown-out advances four-state dimming counter, wraps
// - levels 100, 70, 25, 5 percent
// - dimming reset by supply reset or 3 s
// - first pulses after one time-out while dimmed
// - valley on fall below 55 mV; 6.5 us time-out
// - time-out pulses count as missing valleys
// - 90 ms short timer faults, latch or 4 s
// - first valley undimmed at low line, second at high line, else selected valley count
// - low line after 25 ms; high line immediately
// - valleys 1/2/5 low, 2/3/6 high, foldback as 70%
// - decimal counter of detected valleys
// - 40 us extra dead time in 5% state
// - brown-out flag after 25 ms blanking, stops operation
module ldsv_ctrl #(
    parameter logic [31:0] AUX_SHORT_CYC = ldsv_pkg::AUX_SHORT_CYC,
    parameter logic [31:0] RESTART_CYC   = ldsv_pkg::RESTART_CYC,
    parameter logic [31:0] DIM_RESET_CYC = ldsv_pkg::DIM_RESET_CYC,
    parameter logic [31:0] LOW_LINE_CYC  = ldsv_pkg::LOW_LINE_CYC,
    parameter logic [31:0] BO_BLANK_CYC  = ldsv_pkg::BO_BLANK_CYC
) (
    // clock and reset
    input  wire logic       sys_clk,
    input  wire logic       rst_n,
    // supply comparators, asynchronous
    input  wire logic       supply_ok,
    input  wire logic       vcc_below_reset,
    // valley sense comparators, asynchronous
    input  wire logic       valley_sense_low,
    input  wire logic       valley_sense_short_level,
    // line sense comparators, asynchronous
    input  wire logic       line_below_brownout_off,
    input  wire logic       line_above_brownout_on,
    input  wire logic       line_below_low_line_level,
    input  wire logic       line_above_high_line_level,
    // compensation amplifier, asynchronous
    input  wire logic       transconductance_amp_sinking,
    // on-chip logic, same clock
    input  wire logic       on_time_active,
    input  wire logic       thermal_foldback_active,
    input  wire logic       latch_variant,
    // compensation node control
    output logic            comp_ground,
    output logic            comp_boost_en,
    // current reference
    output logic [1:0]      selected_current_reference,
    output logic [6:0]      current_level_pct,
    // switching
    output logic            drive_start,
    output logic            timeout_pulse,
    // status
    output logic            brownout_fault_flag,
    output logic            high_line,
    output logic            aux_short_protect,
    output logic            fault_stop,
    output logic            latched_off
);

    typedef struct packed {
        logic [ldsv_pkg::SYNC_W-1:0] s1;
        logic [ldsv_pkg::SYNC_W-1:0] s2;
        ldsv_pkg::ldsv_state_type    fsm;
        logic                        comp_primed;
        logic                        ota_sank;
        logic                        startup_max;
        logic                        first_pulse;
        logic                        armed;
        logic                        in_dead;
        logic                        valley_prev;
        logic                        bo_flag;
        logic                        bo_prev;
        logic                        high_line;
        logic                        aux_trip;
        logic [1:0]                  dim;
        logic [3:0]                  valleys;
        logic [31:0]                 aux_cnt;
        logic [31:0]                 rest_cnt;
        logic [11:0]                 dead_cnt;
        logic                        comp_ground;
        logic                        comp_boost;
        logic [1:0]                  ref_sel;
        logic [6:0]                  level_pct;
        logic                        drive_start;
        logic                        timeout;
        logic                        latched;
    } ldsv_ctrl_type;

    ldsv_ctrl_type r_reg;
    ldsv_ctrl_type r_next;

    logic timeout_tick;
    logic low_line_expired;
    logic bo_expired;
    logic dim_reset_expired;

    // valley number that releases the next pulse
    function automatic logic [3:0] valley_target(input logic [1:0] step,
                                                 input logic       hl,
                                                 input logic       thermal);
        logic [1:0] s;
        s = step;
        // thermal foldback alone skips like the 70% step
        if (thermal && step == ldsv_pkg::DIM_FULL) begin
            s = ldsv_pkg::DIM_70;
        end
        case (s)
            ldsv_pkg::DIM_FULL: valley_target = hl ? ldsv_pkg::VAL_HL_FULL : ldsv_pkg::VAL_LL_FULL;
            ldsv_pkg::DIM_70:   valley_target = hl ? ldsv_pkg::VAL_HL_70 : ldsv_pkg::VAL_LL_70;
            default:            valley_target = hl ? ldsv_pkg::VAL_HL_LOW : ldsv_pkg::VAL_LL_LOW;
        endcase
    endfunction

    function automatic logic [6:0] step_pct(input logic [1:0] step);
        case (step)
            ldsv_pkg::DIM_FULL: step_pct = ldsv_pkg::PCT_FULL;
            ldsv_pkg::DIM_70:   step_pct = ldsv_pkg::PCT_70;
            ldsv_pkg::DIM_25:   step_pct = ldsv_pkg::PCT_25;
            default:            step_pct = ldsv_pkg::PCT_5;
        endcase
    endfunction

    // repeats while the valley sense stays low
    ldsv_hold_timer #(
        .LIMIT (ldsv_pkg::TIMEOUT_CYC),
        .WRAP  (1'b1)
    ) u_timeout (
        .sys_clk (sys_clk),
        .rst_n   (rst_n),
        .run     (r_reg.s2[ldsv_pkg::SI_VALLEY_LOW]),
        .expired (timeout_tick)
    );

    ldsv_hold_timer #(
        .LIMIT (LOW_LINE_CYC),
        .WRAP  (1'b0)
    ) u_low_line (
        .sys_clk (sys_clk),
        .rst_n   (rst_n),
        .run     (r_reg.s2[ldsv_pkg::SI_LOW_LINE]),
        .expired (low_line_expired)
    );

    ldsv_hold_timer #(
        .LIMIT (BO_BLANK_CYC),
        .WRAP  (1'b0)
    ) u_bo_blank (
        .sys_clk (sys_clk),
        .rst_n   (rst_n),
        .run     (r_reg.s2[ldsv_pkg::SI_BO_OFF]),
        .expired (bo_expired)
    );

    ldsv_hold_timer #(
        .LIMIT (DIM_RESET_CYC),
        .WRAP  (1'b0)
    ) u_dim_reset (
        .sys_clk (sys_clk),
        .rst_n   (rst_n),
        .run     (r_reg.s2[ldsv_pkg::SI_BO_OFF]),
        .expired (dim_reset_expired)
    );

    always_comb begin
        logic       vcc_reset;
        logic       zcd_ok;
        logic       valley_clk;
        logic       fire;
        logic [1:0] eff_step;
        logic [3:0] nv;
        vcc_reset  = 1'b0;
        zcd_ok     = 1'b0;
        valley_clk = 1'b0;
        fire       = 1'b0;
        eff_step   = 2'h0;
        nv         = 4'h0;

        r_next             = r_reg;
        r_next.drive_start = 1'b0;
        r_next.s1 = {transconductance_amp_sinking, line_above_high_line_level, line_below_low_line_level,
                     line_above_brownout_on, line_below_brownout_off, valley_sense_short_level,
                     valley_sense_low, vcc_below_reset, supply_ok};
        r_next.s2 = r_reg.s1;

        vcc_reset = r_reg.s2[ldsv_pkg::SI_VCC_RESET];
        zcd_ok    = r_reg.s2[ldsv_pkg::SI_ZCD_SHORT];

        // a valley or a time-out clocks the counter
        r_next.valley_prev = r_reg.s2[ldsv_pkg::SI_VALLEY_LOW];
        valley_clk = (r_reg.s2[ldsv_pkg::SI_VALLEY_LOW] && !r_reg.valley_prev) || timeout_tick;

        // brown-out flag, set after blanking, cleared above the on level
        if (bo_expired) begin
            r_next.bo_flag = 1'b1;
        end else if (r_reg.s2[ldsv_pkg::SI_BO_ON]) begin
            r_next.bo_flag = 1'b0;
        end

        // one step per brown-out edge, 5% wraps back to full
        r_next.bo_prev = r_reg.bo_flag;
        if (vcc_reset || dim_reset_expired) begin
            r_next.dim = ldsv_pkg::DIM_FULL;
        end else if (r_reg.bo_flag && !r_reg.bo_prev) begin
            r_next.dim = r_reg.dim + 2'h1;
        end

        if (r_reg.s2[ldsv_pkg::SI_HIGH_LINE]) begin
            r_next.high_line = 1'b1;
        end else if (low_line_expired) begin
            r_next.high_line = 1'b0;
        end

        // held through supply cycles, only a supply reset re-arms it
        if (zcd_ok) begin
            r_next.startup_max = 1'b0;
        end else if (vcc_reset) begin
            r_next.startup_max = 1'b1;
        end
        eff_step = r_reg.startup_max ? ldsv_pkg::DIM_FULL : r_reg.dim;

        // short timer is not cleared by a supply cycle
        if (zcd_ok) begin
            r_next.aux_cnt = 32'h0;
        end else if (r_reg.fsm == ldsv_pkg::ST_RUN) begin
            r_next.aux_cnt = r_reg.aux_cnt + 32'h1;
        end

        if (r_reg.fsm == ldsv_pkg::ST_RUN && r_reg.s2[ldsv_pkg::SI_OTA_SINK]) begin
            r_next.ota_sank = 1'b1;
        end

        case (r_reg.fsm)
            ldsv_pkg::ST_OFF: begin
                if (vcc_reset) begin
                    r_next.comp_primed = 1'b0;
                    r_next.ota_sank    = 1'b0;
                end
                if (r_reg.s2[ldsv_pkg::SI_SUPPLY_OK] && !r_reg.bo_flag) begin
                    // retry keeps the compensation level of the last attempt
                    r_next.fsm         = ldsv_pkg::ST_RUN;
                    r_next.first_pulse = 1'b1;
                    r_next.armed       = 1'b1;
                    r_next.in_dead     = 1'b0;
                    r_next.valleys     = 4'h0;
                end
            end
            ldsv_pkg::ST_RUN: begin
                r_next.comp_primed = 1'b1;
                if (!zcd_ok && r_reg.aux_cnt >= AUX_SHORT_CYC - 32'h1) begin
                    r_next.aux_trip    = 1'b1;
                    r_next.aux_cnt     = 32'h0;
                    r_next.rest_cnt    = 32'h0;
                    r_next.comp_primed = 1'b0;
                    r_next.ota_sank    = 1'b0;
                    r_next.fsm = latch_variant ? ldsv_pkg::ST_LATCHED : ldsv_pkg::ST_WAIT;
                end else if (!r_reg.s2[ldsv_pkg::SI_SUPPLY_OK] || r_reg.bo_flag) begin
                    r_next.fsm = ldsv_pkg::ST_OFF;
                end else if (on_time_active) begin
                    r_next.armed   = 1'b1;
                    r_next.in_dead = 1'b0;
                    r_next.valleys = 4'h0;
                end else if (r_reg.armed) begin
                    if (r_reg.in_dead) begin
                        r_next.dead_cnt = r_reg.dead_cnt + 12'h1;
                        fire = (r_reg.dead_cnt == ldsv_pkg::DEAD_CYC - 12'h1);
                    end else if (valley_clk) begin
                        nv = (r_reg.valleys == ldsv_pkg::VAL_MAX) ? r_reg.valleys : r_reg.valleys + 4'h1;
                        r_next.valleys = nv;
                        if (r_reg.first_pulse) begin
                            fire = 1'b1;
                        end else if (nv >= valley_target(eff_step, r_reg.high_line, thermal_foldback_active)) begin
                            if (eff_step == ldsv_pkg::DIM_5) begin
                                r_next.in_dead  = 1'b1;
                                r_next.dead_cnt = 12'h0;
                            end else begin
                                fire = 1'b1;
                            end
                        end
                    end
                end
                if (fire) begin
                    r_next.drive_start = 1'b1;
                    r_next.armed       = 1'b0;
                    r_next.first_pulse = 1'b0;
                    r_next.in_dead     = 1'b0;
                    r_next.valleys     = 4'h0;
                end
            end
            ldsv_pkg::ST_WAIT: begin
                r_next.rest_cnt = r_reg.rest_cnt + 32'h1;
                if (r_reg.rest_cnt == RESTART_CYC - 32'h1) begin
                    r_next.fsm      = ldsv_pkg::ST_OFF;
                    r_next.aux_trip = 1'b0;
                end
            end
            ldsv_pkg::ST_LATCHED: begin
                // only a supply reset releases the latch
                if (vcc_reset) begin
                    r_next.fsm      = ldsv_pkg::ST_OFF;
                    r_next.aux_trip = 1'b0;
                end
            end
            default: begin
                r_next.fsm = ldsv_pkg::ST_OFF;
            end
        endcase

        r_next.comp_ground = (r_next.fsm != ldsv_pkg::ST_RUN) && !r_next.comp_primed;
        r_next.comp_boost  = (r_next.fsm == ldsv_pkg::ST_RUN) && !r_next.ota_sank;
        r_next.ref_sel     = r_next.startup_max ? ldsv_pkg::DIM_FULL : r_next.dim;
        r_next.level_pct   = step_pct(r_next.ref_sel);
        r_next.timeout     = timeout_tick;
        r_next.latched     = r_next.fsm == ldsv_pkg::ST_LATCHED;
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            r_reg             <= '0;
            r_reg.fsm         <= ldsv_pkg::ST_OFF;
            r_reg.startup_max <= 1'b1;
            r_reg.comp_ground <= 1'b1;
            r_reg.level_pct   <= ldsv_pkg::PCT_FULL;
        end else begin
            r_reg <= r_next;
        end
    end

    assign comp_ground                = r_reg.comp_ground;
    assign comp_boost_en              = r_reg.comp_boost;
    assign selected_current_reference = r_reg.ref_sel;
    assign current_level_pct          = r_reg.level_pct;
    assign drive_start                = r_reg.drive_start;
    assign timeout_pulse              = r_reg.timeout;
    assign brownout_fault_flag        = r_reg.bo_flag;
    assign high_line                  = r_reg.high_line;
    assign aux_short_protect          = r_reg.aux_trip;
    assign fault_stop                 = r_reg.aux_trip;
    assign latched_off                = r_reg.latched;

endmodule

//--- ldsv_stage_model.sv
`timescale 1ns/1ps
// far side: gate on-time, demagnetising aux pulse, then damped ringing
module ldsv_stage_model #(
    parameter int RINGS = 9
) (
    // clock and reset
    input  wire logic sys_clk,
    input  wire logic rst_n,
    // drive and load condition
    input  wire logic drive_start,
    input  wire logic load_ok,
    // comparator views
    output logic      on_time_active,
    output logic      valley_sense_low,
    output logic      valley_sense_short_level
);
    int unsigned cnt;

    always @(posedge sys_clk) begin
        if (!rst_n)
            cnt <= 0;
        else if (drive_start)
            cnt <= 1;
        else if (cnt != 0 && cnt < 100000)
            cnt <= cnt + 1;
    end

    // a shorted load never rings, so only time-outs clock valleys
    always_comb begin
        on_time_active           = cnt >= 1 && cnt <= 20;
        valley_sense_short_level = load_ok && cnt > 20 && cnt <= 60;
        if (!load_ok || cnt == 0 || cnt > 60 + 40 * RINGS)
            valley_sense_low = 1'b1;
        else
            valley_sense_low = cnt > 60 && (cnt - 61) % 40 >= 20;
    end
endmodule

//--- ldsv_ctrl_chk.sv
`timescale 1ns/1ps
module ldsv_ctrl_chk (
    // clock and reset
    input wire logic       sys_clk,
    input wire logic       rst_n,
    // watched inputs
    input wire logic       valley_sense_low,
    input wire logic       line_below_brownout_off,
    input wire logic       line_above_high_line_level,
    input wire logic       on_time_active,
    // watched outputs
    input wire logic       comp_ground,
    input wire logic       comp_boost_en,
    input wire logic [1:0] selected_current_reference,
    input wire logic [6:0] current_level_pct,
    input wire logic       drive_start,
    input wire logic       timeout_pulse,
    input wire logic       brownout_fault_flag,
    input wire logic       high_line,
    input wire logic       aux_short_protect,
    input wire logic       fault_stop,
    input wire logic       latched_off
);
    localparam logic [6:0] PCT [4] = '{7'h64, 7'h46, 7'h19, 7'h05};

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);

    property p_boost_gnd;
        comp_boost_en |-> !comp_ground;
    endproperty
    a_boost_gnd: assert property (p_boost_gnd) else $error("boost on with node grounded");
    property p_fault_gnd;
        aux_short_protect |-> comp_ground && fault_stop && !comp_boost_en;
    endproperty
    a_fault_gnd: assert property (p_fault_gnd) else $error("short fault without stop");
    property p_pct_map;
        current_level_pct == PCT[selected_current_reference];
    endproperty
    a_pct_map: assert property (p_pct_map) else $error("level does not match step");
    property p_ds_once;
        drive_start |=> !drive_start [*2];
    endproperty
    a_ds_once: assert property (p_ds_once) else $error("drive start longer than one cycle");
    property p_ds_cause;
        drive_start |-> !$past(on_time_active) && !fault_stop;
    endproperty
    a_ds_cause: assert property (p_ds_cause) else $error("drive start while on or stopped");
    property p_to_cause;
        timeout_pulse |-> $past(valley_sense_low, 10) ##1 !timeout_pulse;
    endproperty
    a_to_cause: assert property (p_to_cause) else $error("time-out without low sense");
    property p_bo_cause;
        $rose(brownout_fault_flag) |-> $past(line_below_brownout_off, 3);
    endproperty
    a_bo_cause: assert property (p_bo_cause) else $error("brownout flag without low line");
    property p_hl_cause;
        $rose(high_line) |-> $past(line_above_high_line_level, 3);
    endproperty
    a_hl_cause: assert property (p_hl_cause) else $error("high line without high level");
    property p_latch;
        latched_off |-> fault_stop && comp_ground && !drive_start;
    endproperty
    a_latch: assert property (p_latch) else $error("latched state still active");

    c_ds: cover property (drive_start);
    c_to: cover property (timeout_pulse);
    c_aux: cover property ($rose(aux_short_protect));
    c_bo: cover property ($rose(brownout_fault_flag));
endmodule

bind ldsv_ctrl ldsv_ctrl_chk ldsv_ctrl_chk_inst (
    .sys_clk, .rst_n, .valley_sense_low, .line_below_brownout_off,
    .line_above_high_line_level, .on_time_active, .comp_ground, .comp_boost_en,
    .selected_current_reference, .current_level_pct, .drive_start, .timeout_pulse,
    .brownout_fault_flag, .high_line, .aux_short_protect, .fault_stop, .latched_off
);

//--- ldsv_ctrl_test.sv
`timescale 1ns/1ps
module ldsv_ctrl_test;
    localparam int AUX = 10000;
    localparam int RST = 500;
    logic       sys_clk, rst_n, supply_ok, vcc_rst, bo_off, bo_on, ll_low, hl_high;
    logic       amp_sink, latch_v, load_ok, on_time, vs_low, vs_short, therm;
    logic       comp_ground, comp_boost_en, drive_start, timeout_pulse, bo_flag;
    logic       high_line, aux_short, fault_stop, latched_off;
    logic [1:0] ref_sel;
    logic [6:0] level;
    int         n_mismatch, n_compared, c;
    int         val_tab [2][4] = '{'{1, 2, 5, 5}, '{2, 3, 6, 6}};
    logic [6:0] pct_tab [4] = '{7'h64, 7'h46, 7'h19, 7'h05};

    ldsv_ctrl #(.AUX_SHORT_CYC(32'(AUX)), .RESTART_CYC(32'(RST)), .DIM_RESET_CYC(32'h0000_012c),
        .LOW_LINE_CYC(32'h0000_0032), .BO_BLANK_CYC(32'h0000_0032)) ldsv_ctrl_inst (
        .sys_clk, .rst_n, .supply_ok, .vcc_below_reset(vcc_rst), .valley_sense_low(vs_low),
        .valley_sense_short_level(vs_short), .line_below_brownout_off(bo_off),
        .line_above_brownout_on(bo_on), .line_below_low_line_level(ll_low),
        .line_above_high_line_level(hl_high), .transconductance_amp_sinking(amp_sink),
        .on_time_active(on_time), .thermal_foldback_active(therm), .latch_variant(latch_v),
        .comp_ground, .comp_boost_en, .selected_current_reference(ref_sel), .current_level_pct(level),
        .drive_start, .timeout_pulse, .brownout_fault_flag(bo_flag), .high_line,
        .aux_short_protect(aux_short), .fault_stop, .latched_off);

    ldsv_stage_model ldsv_stage_model_inst (.sys_clk, .rst_n, .drive_start, .load_ok,
        .on_time_active(on_time), .valley_sense_low(vs_low), .valley_sense_short_level(vs_short));

    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end

    task automatic close_out();
        $display("compared %0d mismatches %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_compared++;
        if (got !== exp) begin
            n_mismatch++;
            $display("mismatch %s expected %0h seen %0h", what, exp, got);
        end
    endtask

    function automatic logic sig(input int w);
        case (w)
            0: return drive_start;
            1: return aux_short;
            2: return comp_boost_en;
            default: return timeout_pulse;
        endcase
    endfunction

    // a wait that runs out fails the run
    task automatic wait_for(input int w, input int bound, output int cyc);
        cyc = 0;
        #1;
        while (sig(w) !== 1'b1) begin
            tick(1);
            cyc++;
            if (cyc > bound) begin
                n_mismatch++;
                $display("mismatch wait %0d expected 1 seen 0", w);
                close_out();
            end
        end
    endtask

    task automatic brownout(input int hold, input logic exp);
        @(posedge sys_clk) bo_on <= 1'b0;
        @(posedge sys_clk) bo_off <= 1'b1;
        tick(hold);
        chk("brownout flag", exp, bo_flag);
        @(posedge sys_clk) bo_off <= 1'b0;
        @(posedge sys_clk) bo_on <= 1'b1;
        tick(6);
    endtask

    // later gaps show the valley used
    task automatic run_step(input int k, input int st);
        int g, exp;
        exp = 44 + 40 * k + (st == 3 ? 4000 : 0);
        wait_for(0, 800, g);
        repeat (2) begin
            tick(1);
            wait_for(0, 5000, g);
        end
        n_compared++;
        if (g + 1 < exp - 2 || g + 1 > exp + 4) begin
            n_mismatch++;
            $display("mismatch pulse gap expected %0d seen %0d", exp, g + 1);
        end
        chk("ref", st, ref_sel);
        chk("level", pct_tab[st], level);
    endtask

    initial begin
        n_mismatch = 0;
        n_compared = 0;
        {rst_n, supply_ok, vcc_rst, bo_off, hl_high, amp_sink, latch_v, load_ok, therm} = 9'h000;
        {bo_on, ll_low} = 2'h3;
        tick(2);
        chk("comp_ground", 1, comp_ground);
        chk("level", 32'h64, level);
        @(posedge sys_clk) rst_n <= 1'b1;
        @(posedge sys_clk) supply_ok <= 1'b1;
        tick(6);
        chk("comp_ground", 0, comp_ground);
        chk("boost", 1, comp_boost_en);
        @(posedge sys_clk) amp_sink <= 1'b1;
        tick(6);
        chk("boost", 0, comp_boost_en);
        brownout(40, 1'b0);
        brownout(70, 1'b1);
        chk("ref", 0, ref_sel);
        @(posedge sys_clk) load_ok <= 1'b1;
        for (int n = 0; n < 8; n++) begin
            if (n == 4) begin
                @(posedge sys_clk) hl_high <= 1'b1;
                @(posedge sys_clk) ll_low <= 1'b0;
                tick(5);
                chk("high_line", 1, high_line);
            end
            if (n > 0)
                brownout(70, 1'b1);
            run_step(val_tab[n / 4][(n + 1) % 4], (n + 1) % 4);
        end
        @(posedge sys_clk) therm <= 1'b1;
        run_step(3, 0);
        brownout(70, 1'b1);
        brownout(350, 1'b1);
        chk("ref", 0, ref_sel);
        @(posedge sys_clk) hl_high <= 1'b0;
        @(posedge sys_clk) ll_low <= 1'b1;
        tick(30);
        chk("high_line", 1, high_line);
        tick(40);
        chk("high_line", 0, high_line);
        brownout(70, 1'b1);
        @(posedge sys_clk) supply_ok <= 1'b0;
        @(posedge sys_clk) vcc_rst <= 1'b1;
        amp_sink <= 1'b0;
        tick(6);
        chk("ref", 0, ref_sel);
        chk("comp_ground", 1, comp_ground);
        @(posedge sys_clk) vcc_rst <= 1'b0;
        @(posedge sys_clk) supply_ok <= 1'b1;
        tick(6);
        chk("boost", 1, comp_boost_en);
        @(posedge sys_clk) amp_sink <= 1'b1;
        tick(100);
        @(posedge sys_clk) load_ok <= 1'b0;
        wait_for(3, 1400, c);
        tick(1);
        wait_for(3, 700, c);
        chk("timeout gap", 650, c + 1);
        wait_for(0, 1400, c);
        tick(5000);
        @(posedge sys_clk) supply_ok <= 1'b0;
        tick(20);
        chk("comp_ground", 0, comp_ground);
        @(posedge sys_clk) supply_ok <= 1'b1;
        wait_for(1, 5000, c);
        chk("fault_stop", 1, fault_stop);
        @(posedge sys_clk) amp_sink <= 1'b0;
        wait_for(2, RST + 200, c);
        chk("restart delay", 1, c >= RST - 50);
        @(posedge sys_clk) latch_v <= 1'b1;
        wait_for(1, AUX + 2000, c);
        tick(RST + 200);
        chk("latched", 1, latched_off);
        close_out();
    end
endmodule
